// [core/sas_defs.svh]
// Notes on behaviour
// - A conversion yields a 10-bit value by successive approximation, kept as a high/low pair.
// - Each completed conversion can raise an interrupt request.
// - An enabled completion interrupt also serves as a wake-up out of Sleep.
// - The channel field picks the one input routed to the shared sample-and-hold.
// - Up to 21 selections exist on the small variant and 32 on the large ones.
// - The positive reference is the pin, the supply, 2.048V or 4.096V (absent on LV parts).
// - One bit picks the negative reference pin or ground.
// - Clock select 000,100,001,101,010,110 divide by 2,4,8,16,32,64; x11 picks the RC clock.
// - A full conversion lasts 11.5 bit periods.
// - A divided source follows the system clock; the RC source does not.
// - On completion the start bit clears, the done flag sets and the result loads.
// - A start takes effect only when the converter is already enabled; it reads set until done or an abort.
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// Register byte offsets
`define SAS_OFS_CTRL0 8'h00
`define SAS_OFS_CTRL1 8'h04
`define SAS_OFS_RES_HI 8'h08
`define SAS_OFS_RES_LO 8'h0C
`define SAS_OFS_STATUS 8'h10
`define SAS_OFS_MASK 8'h14

// Field positions
`define SAS_CTRL0_EN_BIT 0
`define SAS_CTRL0_GO_BIT 1
`define SAS_CTRL0_CH_LSB 2
`define SAS_CTRL1_PREF_LSB 0
`define SAS_CTRL1_NREF_BIT 2
`define SAS_CTRL1_CS_LSB 4
`define SAS_STAT_DONE_BIT 0

// Reset values
`define SAS_CTRL0_RST 7'h00
`define SAS_CTRL1_RST 6'h00
`define SAS_RESULT_RST 10'h000

// Clock select codes
`define SAS_CS_DIV2 3'h0
`define SAS_CS_DIV4 3'h4
`define SAS_CS_DIV8 3'h1
`define SAS_CS_DIV16 3'h5
`define SAS_CS_DIV32 3'h2
`define SAS_CS_DIV64 3'h6
`define SAS_CS_RC_LOW 2'h3

// Last count of a half bit period, in system clocks, per divisor
`define SAS_HLAST_DIV2 5'h00
`define SAS_HLAST_DIV4 5'h01
`define SAS_HLAST_DIV8 5'h03
`define SAS_HLAST_DIV16 5'h07
`define SAS_HLAST_DIV32 5'h0F
`define SAS_HLAST_DIV64 5'h1F

// Conversion length in half bit periods (11.5 periods)
`define SAS_CONV_HALVES 5'd23
`define SAS_FINISH_HALVES 1'b1
`define SAS_PREF_4V096 2'h3

`endif

// [core/sas_pkg.sv]
package sas_pkg;

    // Conversion sequencer states
    typedef enum logic [3:0] {
        SAS_IDLE    = 4'b0001,
        SAS_SAMPLE  = 4'b0010,
        SAS_CONVERT = 4'b0100,
        SAS_FINISH  = 4'b1000
    } sas_state_type;

    typedef struct packed {
        logic [4:0] channel_select;
        logic go;
        logic converter_enable;
    } sas_ctrl0_type;

    typedef struct packed {
        logic [2:0] conv_clock_select;
        logic negative_ref_select;
        logic [1:0] positive_ref_select;
    } sas_ctrl1_type;

    // Captured AHB address phase
    typedef struct packed {
        logic write;
        logic [7:0] addr;
    } sas_aphase_type;

    // Controls toward the analog front end
    typedef struct packed {
        logic [4:0] channel_select;
        logic [1:0] positive_ref_select;
        logic negative_ref_select;
        logic track;
        logic [9:0] trial_code;
    } sas_analog_type;

endpackage

// [core/sas_tick.sv]
`timescale 1ns/1ns
`include "sas_defs.svh"
module sas_tick import sas_pkg::*; (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic [2:0] sel, // Conversion clock select
    input wire logic rc_sync, // Synchronised RC oscillator level
    input wire logic run, // Conversion in progress
    output logic half_tick // One half bit period elapsed
);
    logic [4:0] cnt_ff;
    logic rc_prev_ff;
    logic [4:0] half_last;
    logic use_rc;

    // Divisor decode; the divided sources scale with hclk itself
    always_comb begin
        use_rc = (sel[1:0] == `SAS_CS_RC_LOW);
        unique case (sel)
            `SAS_CS_DIV2: half_last = `SAS_HLAST_DIV2;
            `SAS_CS_DIV4: half_last = `SAS_HLAST_DIV4;
            `SAS_CS_DIV8: half_last = `SAS_HLAST_DIV8;
            `SAS_CS_DIV16: half_last = `SAS_HLAST_DIV16;
            `SAS_CS_DIV32: half_last = `SAS_HLAST_DIV32;
            `SAS_CS_DIV64: half_last = `SAS_HLAST_DIV64;
            default: half_last = `SAS_HLAST_DIV2;
        endcase
    end

    // Prescaler restarts with each conversion for a clean first period
    // At or past the last count wraps, so a divisor change mid-run cannot overrun
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 5'h00;
        end else if (!run || cnt_ff >= half_last) begin
            cnt_ff <= 5'h00;
        end else begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    // Each RC edge is a half period, independent of hclk rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_prev_ff <= 1'b0;
        end else begin
            rc_prev_ff <= rc_sync;
        end
    end

    assign half_tick = run & (use_rc ? (rc_sync ^ rc_prev_ff) : (cnt_ff == half_last));
endmodule

// [core/sas_sar.sv]
`timescale 1ns/1ns
module sas_sar import sas_pkg::*; #(
    parameter int WIDTH = 10
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic load, // Start a new approximation
    input wire logic step, // Decide the current trial bit
    input wire logic comp, // Input at or above trial level
    output logic [WIDTH-1:0] trial, // Code driven to the DAC
    output logic [WIDTH-1:0] partial, // Result with undecided bits filled
    output logic final_step // Current trial bit is the LSB
);
    logic [WIDTH-1:0] approx_ff;
    logic [WIDTH-1:0] mask_ff;
    logic last_bit_ff;
    logic [WIDTH-1:0] undecided;

    // Walks a single one from MSB down, one decision per step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            approx_ff <= '0;
            mask_ff <= '0;
            last_bit_ff <= 1'b0;
        end else if (load) begin
            approx_ff <= '0;
            mask_ff <= {1'b1, {(WIDTH-1){1'b0}}};
            last_bit_ff <= 1'b0;
        end else if (step && mask_ff != '0) begin
            approx_ff <= comp ? (approx_ff | mask_ff) : approx_ff;
            last_bit_ff <= comp;
            mask_ff <= mask_ff >> 1;
        end
    end

    // Bits not yet resolved copy the last resolved bit on abort
    always_comb begin
        undecided = (mask_ff == '0) ? '0 : (mask_ff | (mask_ff - 1'b1));
        partial = approx_ff | (last_bit_ff ? undecided : '0);
    end

    assign trial = approx_ff | mask_ff;
    assign final_step = mask_ff[0];
endmodule

// [core/sas_top.sv]
`timescale 1ns/1ns
`include "sas_defs.svh"
module sas_top import sas_pkg::*; #(
    parameter int NUM_CHANNELS = 32,
    parameter bit HAS_REF_4V096 = 1'b1,
    parameter int RES_BITS = 10
) (
    input wire logic hclk, // System clock, 125 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word only, not decoded
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic comp_in, // Comparator pin
    input wire logic rc_osc_in, // Internal RC oscillator
    input wire logic sleep_in, // Device in Sleep
    output sas_analog_type analog, // Analog front end controls
    output logic irq, // Level interrupt
    output logic wake // Wake request from Sleep
);
    sas_ctrl0_type ctrl0_ff;
    sas_ctrl1_type ctrl1_ff;
    sas_aphase_type aph_ff;
    sas_state_type state_ff;
    logic [RES_BITS-1:0] result_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_data;
    logic status_ff;
    logic mask_ff;
    logic phase_ff;
    logic fin_cnt_ff;
    logic [4:0] ht_cnt_ff;
    logic comp_s1_ff, comp_s2_ff;
    logic rc_s1_ff, rc_s2_ff;
    logic aph_valid, wr_ctrl0, wr_ctrl1, wr_status, wr_mask;
    logic start, abort_sw, abort_off, abort_sleep, abort_any, done;
    logic half_tick, sar_step, final_step, busy, rc_sel;
    logic [RES_BITS-1:0] trial, partial;
    logic [4:0] wr_chan;
    logic chan_ok;

    // Zero wait state slave; reads are registered in the address phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign aph_valid = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_ff <= '0;
        end else if (hready) begin
            aph_ff.write <= aph_valid & hwrite;
            aph_ff.addr <= haddr[7:0];
        end
    end

    // Write strobes land at the end of the data phase
    always_comb begin
        wr_ctrl0 = aph_ff.write & hready & (aph_ff.addr == `SAS_OFS_CTRL0);
        wr_ctrl1 = aph_ff.write & hready & (aph_ff.addr == `SAS_OFS_CTRL1);
        wr_status = aph_ff.write & hready & (aph_ff.addr == `SAS_OFS_STATUS);
        wr_mask = aph_ff.write & hready & (aph_ff.addr == `SAS_OFS_MASK);
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (haddr[7:0])
            `SAS_OFS_CTRL0: rd_data[6:0] = ctrl0_ff;
            `SAS_OFS_CTRL1: rd_data[6:4] = ctrl1_ff.conv_clock_select;
            `SAS_OFS_RES_HI: rd_data[1:0] = result_ff[RES_BITS-1:8];
            `SAS_OFS_RES_LO: rd_data[7:0] = result_ff[7:0];
            `SAS_OFS_STATUS: rd_data[0] = status_ff;
            `SAS_OFS_MASK: rd_data[0] = mask_ff;
            default: rd_data = 32'h0000_0000;
        endcase
        if (haddr[7:0] == `SAS_OFS_CTRL1) begin
            rd_data[`SAS_CTRL1_NREF_BIT] = ctrl1_ff.negative_ref_select;
            rd_data[1:0] = ctrl1_ff.positive_ref_select;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (aph_valid && !hwrite) begin
            hrdata_ff <= rd_data;
        end
    end

    // Pin inputs pass two flops before any logic looks at them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
            rc_s1_ff <= 1'b0;
            rc_s2_ff <= 1'b0;
        end else begin
            comp_s1_ff <= comp_in;
            comp_s2_ff <= comp_s1_ff;
            rc_s1_ff <= rc_osc_in;
            rc_s2_ff <= rc_s1_ff;
        end
    end

    // Start and abort decode; go in the enabling write is ignored
    assign busy = (state_ff != SAS_IDLE);
    assign rc_sel = (ctrl1_ff.conv_clock_select[1:0] == `SAS_CS_RC_LOW);
    assign start = wr_ctrl0 & hwdata[`SAS_CTRL0_GO_BIT] & hwdata[`SAS_CTRL0_EN_BIT]
        & ctrl0_ff.converter_enable & ~busy;
    assign abort_sw = busy & wr_ctrl0 & ~hwdata[`SAS_CTRL0_GO_BIT];
    assign abort_off = busy & wr_ctrl0 & ~hwdata[`SAS_CTRL0_EN_BIT];
    // Without the RC clock the hclk source stops in Sleep, so abort
    assign abort_sleep = busy & sleep_in & ~rc_sel;
    assign abort_any = abort_sw | abort_off | abort_sleep;
    assign done = (state_ff == SAS_FINISH) & half_tick & fin_cnt_ff & ~abort_any;
    assign sar_step = (state_ff == SAS_CONVERT) & half_tick & phase_ff & ~abort_any;

    // Out-of-range channels are dropped so the mux never sees them
    assign wr_chan = hwdata[`SAS_CTRL0_CH_LSB+4:`SAS_CTRL0_CH_LSB];
    assign chan_ok = ({1'b0, wr_chan} < 6'(NUM_CHANNELS));

    // Control register 0: channel, start, enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0_ff <= `SAS_CTRL0_RST;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_ff.converter_enable <= hwdata[`SAS_CTRL0_EN_BIT];
                if (chan_ok) begin
                    ctrl0_ff.channel_select <= wr_chan;
                end
            end
            if (start) begin
                ctrl0_ff.go <= 1'b1;
            end else if (done || abort_any) begin
                ctrl0_ff.go <= 1'b0;
            end
        end
    end

    // Control register 1: clock, references
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1_ff <= `SAS_CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1_ff.conv_clock_select <= hwdata[`SAS_CTRL1_CS_LSB+2:`SAS_CTRL1_CS_LSB];
            ctrl1_ff.negative_ref_select <= hwdata[`SAS_CTRL1_NREF_BIT];
            // The 4.096V code is refused on parts that lack it
            if (HAS_REF_4V096 || hwdata[1:0] != `SAS_PREF_4V096) begin
                ctrl1_ff.positive_ref_select <= hwdata[1:0];
            end
        end
    end

    // Half period timebase
    sas_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(ctrl1_ff.conv_clock_select),
        .rc_sync(rc_s2_ff),
        .run(busy),
        .half_tick(half_tick)
    );

    // Approximation register
    sas_sar #(.WIDTH(RES_BITS)) u_sar (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(start),
        .step(sar_step),
        .comp(comp_s2_ff),
        .trial(trial),
        .partial(partial),
        .final_step(final_step)
    );

    // Sequencer: half period sampling, 10 bit periods, one closing period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= SAS_IDLE;
        end else if (abort_any) begin
            state_ff <= SAS_IDLE;
        end else begin
            unique case (state_ff)
                SAS_IDLE: if (start) begin
                    state_ff <= SAS_SAMPLE;
                end
                SAS_SAMPLE: if (half_tick) begin
                    state_ff <= SAS_CONVERT;
                end
                SAS_CONVERT: if (sar_step && final_step) begin
                    state_ff <= SAS_FINISH;
                end
                SAS_FINISH: if (done) begin
                    state_ff <= SAS_IDLE;
                end
                default: state_ff <= SAS_IDLE;
            endcase
        end
    end

    // Phase within a bit period and closing period counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= 1'b0;
            fin_cnt_ff <= 1'b0;
        end else if (state_ff == SAS_IDLE) begin
            phase_ff <= 1'b0;
            fin_cnt_ff <= 1'b0;
        end else if (half_tick) begin
            phase_ff <= (state_ff == SAS_CONVERT) ? ~phase_ff : 1'b0;
            fin_cnt_ff <= (state_ff == SAS_FINISH) ? `SAS_FINISH_HALVES : 1'b0;
        end
    end

    // Result: full value on completion, filled partial value on software abort
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ff <= `SAS_RESULT_RST;
        end else if (done) begin
            result_ff <= partial;
        end else if (abort_sw) begin
            result_ff <= partial;
        end
    end

    // Sticky done flag; a new completion beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= 1'b0;
            mask_ff <= 1'b0;
        end else begin
            status_ff <= (status_ff & ~(wr_status & hwdata[`SAS_STAT_DONE_BIT])) | done;
            if (wr_mask) begin
                mask_ff <= hwdata[`SAS_STAT_DONE_BIT];
            end
        end
    end

    assign irq = status_ff & mask_ff;
    assign wake = irq & sleep_in;

    // Analog front end; track while enabled and idle or sampling so the hold cap settles
    always_comb begin
        analog.channel_select = ctrl0_ff.channel_select;
        analog.positive_ref_select = ctrl1_ff.positive_ref_select;
        analog.negative_ref_select = ctrl1_ff.negative_ref_select;
        analog.track = ctrl0_ff.converter_enable & (state_ff == SAS_IDLE || state_ff == SAS_SAMPLE);
        analog.trial_code = trial;
    end

    // Helper count of half periods within one conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ht_cnt_ff <= 5'h00;
        end else if (start) begin
            ht_cnt_ff <= 5'h00;
        end else if (busy && half_tick) begin
            ht_cnt_ff <= ht_cnt_ff + 5'h01;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start;
        start ##1 (state_ff == SAS_SAMPLE);
    endsequence

    sequence s_first_trial;
        (state_ff == SAS_SAMPLE) && half_tick && !abort_any;
    endsequence

    property p_go_needs_enable;
        $rose(ctrl0_ff.go) |-> $past(ctrl0_ff.converter_enable);
    endproperty
    a_go_needs_enable: assert property (p_go_needs_enable)
        else $error("conversion started while converter disabled");

    property p_start_busy;
        s_start |-> ctrl0_ff.go;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start bit not reading set after start");

    property p_conv_length;
        done |-> (ht_cnt_ff == (`SAS_CONV_HALVES - 5'd1));
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion not 23 half periods long");

    property p_done_effects;
        done |=> (status_ff && !ctrl0_ff.go && result_ff == $past(partial));
    endproperty
    a_done_effects: assert property (p_done_effects)
        else $error("completion did not clear go, set flag and load result");

    property p_irq_on_done;
        done && mask_ff && !wr_mask |=> irq;
    endproperty
    a_irq_on_done: assert property (p_irq_on_done)
        else $error("enabled completion gave no interrupt");

    property p_wake;
        done && mask_ff && !wr_mask ##1 sleep_in |-> wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("completion in Sleep did not wake");

    property p_msb_first;
        s_first_trial |=> (trial == {1'b1, {(RES_BITS-1){1'b0}}});
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first trial is not the MSB");

    property p_div2_rate;
        busy && ctrl1_ff.conv_clock_select == `SAS_CS_DIV2 && $stable(ctrl1_ff) |-> half_tick;
    endproperty
    a_div2_rate: assert property (p_div2_rate)
        else $error("divide by 2 not one half period per clock");

    property p_div4_rate;
        half_tick && busy && ctrl1_ff.conv_clock_select == `SAS_CS_DIV4 |=> !half_tick;
    endproperty
    a_div4_rate: assert property (p_div4_rate)
        else $error("divide by 4 ticking too fast");

    property p_nref_write;
        wr_ctrl1 |=> analog.negative_ref_select == $past(hwdata[`SAS_CTRL1_NREF_BIT]);
    endproperty
    a_nref_write: assert property (p_nref_write)
        else $error("negative reference not following write");

    property p_chan_write;
        wr_ctrl0 && chan_ok |=> analog.channel_select == $past(wr_chan);
    endproperty
    a_chan_write: assert property (p_chan_write)
        else $error("channel select not following write");
endmodule

// [tb/sas_top_tb.sv]
`timescale 1ns/1ns
module sas_top_tb import sas_pkg::*;;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic comp_in;
    logic rc_osc_in;
    logic sleep_in;
    logic rc_run;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic wake;
    logic [9:0] target;
    sas_analog_type analog;
    int fails;
    int cmp_count;
    int n;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int dv [6] = '{2, 4, 8, 16, 32, 64};

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    sas_top #(.NUM_CHANNELS(21), .HAS_REF_4V096(1'b0), .RES_BITS(10)) u_sas_top (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .comp_in(comp_in),
        .rc_osc_in(rc_osc_in),
        .sleep_in(sleep_in),
        .analog(analog),
        .irq(irq),
        .wake(wake)
    );

    // 125 MHz system clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Ideal comparator against a fixed input level
    always @(posedge hclk) begin
        comp_in <= (target >= analog.trial_code);
    end

    // Slow RC oscillator, still unless a test wants it
    initial begin
        forever begin
            repeat (10) @(posedge hclk);
            if (rc_run) rc_osc_in <= ~rc_osc_in;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        #1; // Step off the edge so callers see settled outputs
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Bounded wait for the interrupt line, counting clocks
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge hclk);
            #1;
            n++;
        end
        @(posedge hclk);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge hclk);
        fails++;
        wrap_up();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        comp_in = 1'b0;
        rc_osc_in = 1'b0;
        sleep_in = 1'b0;
        rc_run = 1'b0;
        target = 10'h2A5;
        fails = 0;
        cmp_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, unmapped offset included
        foreach (offs[i]) rdchk(offs[i], 32'h0);
        // References; 4.096V refused on this variant
        bus(1'b1, 8'h04, 32'h26);
        chk(analog.positive_ref_select, 2'h2);
        chk(analog.negative_ref_select, 1'b1);
        bus(1'b1, 8'h04, 32'h27);
        rdchk(8'h04, 32'h26);
        // Go with the enabling write is ignored; channel 21 beyond range
        bus(1'b1, 8'h00, 32'h53);
        rdchk(8'h00, 32'h51);
        chk(analog.channel_select, 5'd20);
        chk({hreadyout, hresp, analog.track}, 3'b101);
        bus(1'b1, 8'h00, 32'h55);
        rdchk(8'h00, 32'h51);
        // Settling time after the channel change before any start
        repeat (20) @(posedge hclk);
        // Every divisor: duration, completion side effects
        bus(1'b1, 8'h14, 32'h1);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 8'h04, {25'h0, cs[i], 4'h0});
            bus(1'b1, 8'h00, 32'h53);
            wait_irq();
            chk(n >= 23 * dv[i] / 2 - 2 && n <= 23 * dv[i] / 2 + dv[i] + 4, 1);
            rdchk(8'h00, 32'h51);
            rdchk(8'h10, 32'h1);
            bus(1'b1, 8'h10, 32'h1);
            chk(irq, 1'b0);
        end
        // Last run used the slowest divisor; result is the input level
        rdchk(8'h08, 32'h2);
        rdchk(8'h0C, 32'hA5);
        chk(analog.trial_code, 10'h2A5);
        // Sleep with a divided clock aborts without a flag
        bus(1'b1, 8'h00, 32'h53);
        repeat (60) @(posedge hclk);
        sleep_in <= 1'b1;
        repeat (800) @(posedge hclk);
        chk(wake, 1'b0);
        rdchk(8'h00, 32'h51);
        rdchk(8'h10, 32'h0);
        sleep_in <= 1'b0;
        // Software abort leaves the flag clear
        bus(1'b1, 8'h00, 32'h53);
        repeat (100) @(posedge hclk);
        bus(1'b1, 8'h00, 32'h51);
        repeat (800) @(posedge hclk);
        rdchk(8'h10, 32'h0);
        // RC clock keeps converting in Sleep and wakes the part
        bus(1'b1, 8'h04, 32'h30);
        rc_run <= 1'b1;
        sleep_in <= 1'b1;
        bus(1'b1, 8'h00, 32'h53);
        wait_irq();
        chk(n >= 200 && n <= 270, 1);
        chk(wake, 1'b1);
        sleep_in <= 1'b0;
        rc_run <= 1'b0;
        bus(1'b1, 8'h10, 32'h1);
        // Masked completion still flags but keeps the line low
        bus(1'b1, 8'h14, 32'h0);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h53);
        repeat (60) @(posedge hclk);
        chk(irq, 1'b0);
        rdchk(8'h10, 32'h1);
        wrap_up();
    end
endmodule
